// *** common/asu_pkg.sv ***
/*
 * Constants for the asynchronous serial transceiver core: frame lengths,
 * oversampling, divider encodings and status reset values.
 * Assumes one system clock; no register bus, all control bits are ports.
 */
// Operation
// - Status access then data write clears transmit flags
// - Break_send repeats zero frames, then one mark bit
// - Enabling transmitter sends one idle frame first
// - Tx_on pulse queues idle frame, drops holding data
// - Receive LSB first; ninth bit to rx_ninth_bit
// - Rx_on enables receiver hunting for start bit
// - Completed character loads holding register, sets full
// - Status read then data read clears full
// - Idle frame handled like character plus interrupt
// - Overrun keeps holding register, sets overrun flag
// - Noise flag rises with full, no own interrupt
// - Missing stop or break sets framing fault
// - Baud equals clock over 16, common, direction divider
// - Nonzero fine prescale divides rate further
// - Muted receiver sets no flags, no interrupts; a pending parity fault still raises irq
// - Idle wake clears mute without idle flag
// - Address wake on MSB one, received normally
// - Parity replaces data MSB on transmit
// - Parity even or odd over low bits
// - Parity failure sets fault flag, maybe interrupt
// - All events share one gated interrupt line
// - Idle transmitter loads shift register directly
// - Frame end sets done flag and interrupt
// - Parity settings change only between bytes
// - Clearing rx_on resets receive flags except parity fault
package asu_pkg;
	localparam int unsigned OVERSAMPLE = 16;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] SAMPLE_LAST = 4'hf;
	localparam logic [3:0] BITS_8 = 4'ha;
	localparam logic [3:0] BITS_9 = 4'hb;
	localparam logic [7:0] PRE_1 = 8'h01;
	localparam logic [7:0] PRE_3 = 8'h03;
	localparam logic [7:0] PRE_4 = 8'h04;
	localparam logic [7:0] PRE_13 = 8'h0d;
	localparam logic TXE_RESET = 1'b1;
	localparam logic TXDONE_RESET = 1'b1;
endpackage

// *** src/asu_rate_gen.sv ***
/*
 * One baud tick generator: sixteen-times bit clock enable.
 * Assumes configuration is steady while the direction is enabled.
 */
`timescale 1ns/100ps
module asu_rate_gen #(
	parameter int unsigned CW = 24
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_run,
	input wire logic [1:0] i_common_prescale_field,
	input wire logic [2:0] i_rate_field,
	input wire logic [7:0] i_fine_divisor,
	output logic o_tick
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} asu_rg_t;
	asu_rg_t st_r;
	asu_rg_t st_nxt;
	logic [7:0] pre;
	logic [CW-1:0] limit;

	// Total divide: common times 2^rate times fine, 16x domain
	always_comb begin
		case (i_common_prescale_field)
			2'h0: pre = asu_pkg::PRE_1;
			2'h1: pre = asu_pkg::PRE_3;
			2'h2: pre = asu_pkg::PRE_4;
			default: pre = asu_pkg::PRE_13;
		endcase
		limit = CW'(pre) << i_rate_field;
		if (i_fine_divisor != 8'h00) begin
			limit = CW'(limit * CW'(i_fine_divisor));
		end
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!i_run) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt >= limit - CW'(1)) begin
			st_nxt.cnt = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_tick = st_r.tick;
endmodule

// *** src/asu_core.sv ***
/*
 * Full-duplex asynchronous serial transceiver with break, idle frames,
 * parity, muting with wake-up and gated single interrupt line.
 * Assumes software strobes for status access and data read/write are
 * one-cycle pulses, and rx_line is already synchronous to i_clk_sys.
 */
`timescale 1ns/100ps
module asu_core (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_tx_on,
	input wire logic i_rx_on,
	input wire logic i_break_send,
	input wire logic i_word9,
	input wire logic i_wake_address,
	input wire logic i_parity_on,
	input wire logic i_odd_parity_select,
	input wire logic i_parity_irq_en,
	input wire logic i_rx_irq_en,
	input wire logic i_txe_irq_en,
	input wire logic i_txdone_irq_en,
	input wire logic i_idle_irq_en,
	input wire logic i_global_mask,
	input wire logic i_rx_mute_set,
	input wire logic [1:0] i_common_prescale_field,
	input wire logic [2:0] i_tx_rate_field,
	input wire logic [2:0] i_rx_rate_field,
	input wire logic [7:0] i_tx_fine_divisor,
	input wire logic [7:0] i_rx_fine_divisor,
	input wire logic i_status_read,
	input wire logic i_data_wr,
	input wire logic [7:0] i_data_wdata,
	input wire logic i_tx_ninth_bit,
	input wire logic i_data_rd,
	input wire logic i_rx_line,
	output logic o_tx_line,
	output logic o_tx_line_oe,
	output logic [7:0] o_rx_holding_reg,
	output logic o_rx_ninth_bit,
	output logic o_tx_buffer_empty,
	output logic o_tx_done_flag,
	output logic o_rx_buffer_full,
	output logic o_idle_flag,
	output logic o_overrun_flag,
	output logic o_noise_flag,
	output logic o_framing_fault_flag,
	output logic o_parity_fault_flag,
	output logic o_rx_mute,
	output logic o_irq
);
	typedef enum logic [3:0] {
		TX_OFF = 4'h1, TX_IDLE = 4'h2, TX_SHIFT = 4'h4, TX_MARK = 4'h8
	} asu_txs_t;
	typedef enum logic [2:0] {
		RX_OFF = 3'h1, RX_HUNT = 3'h2, RX_FRAME = 3'h4
	} asu_rxs_t;
	typedef struct packed {
		asu_txs_t txs;
		logic [10:0] tsh;
		logic [3:0] tbits;
		logic [3:0] tsub;
		logic [8:0] thold;
		logic thold_v;
		logic tx_on_d;
		logic idle_pend;
		logic brk_frame;
		logic txe;
		logic txdone;
		logic st_armed;
		asu_rxs_t rxs;
		logic [3:0] rsub;
		logic [3:0] rbit;
		logic [9:0] rsh;
		logic [2:0] votes;
		logic rnoise;
		logic rpar_on;
		logic rodd;
		logic rxfull;
		logic idle;
		logic ovr;
		logic nf;
		logic fe;
		logic pe;
		logic mute;
		logic [7:0] rhold;
		logic r9;
		logic txd;
	} asu_state_t;
	asu_state_t s_r;
	asu_state_t s_nxt;
	logic tx_tick;
	logic rx_tick;
	logic [3:0] tlen;

	// Separate generators keep tx and rx rates independent
	asu_rate_gen #(.CW(24)) u_tx_rate (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_run(i_tx_on),
		.i_common_prescale_field(i_common_prescale_field),
		.i_rate_field(i_tx_rate_field),
		.i_fine_divisor(i_tx_fine_divisor),
		.o_tick(tx_tick)
	);
	asu_rate_gen #(.CW(24)) u_rx_rate (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_run(i_rx_on),
		.i_common_prescale_field(i_common_prescale_field),
		.i_rate_field(i_rx_rate_field),
		.i_fine_divisor(i_rx_fine_divisor),
		.o_tick(rx_tick)
	);

	// Parity over low data bits, odd select inverts
	function automatic logic par_bit(input logic [8:0] d, input logic w9, input logic odd);
		logic p;
		p = w9 ? ^d[7:0] : ^d[6:0];
		return p ^ odd;
	endfunction

	// Build frame: start, data LSB first, stop; parity in MSB slot
	function automatic logic [10:0] mk_frame(input logic [8:0] d, input logic w9,
		input logic pon, input logic odd);
		logic [8:0] x;
		x = d;
		if (pon) begin
			if (w9) x[8] = par_bit(d, 1'b1, odd);
			else x[7] = par_bit(d, 1'b0, odd);
		end
		if (!w9) x[8] = 1'b1;
		return w9 ? {1'b1, x, 1'b0} : {1'b1, 1'b1, x[7:0], 1'b0};
	endfunction

	assign tlen = i_word9 ? asu_pkg::BITS_9 : asu_pkg::BITS_8;

	// Next-state logic for both directions and the shared flags
	always_comb begin
		logic samp;
		logic [8:0] rd;
		logic perr;
		logic clr_seq_w;
		logic clr_seq_r;
		samp = 1'b0;
		rd = '0;
		perr = 1'b0;
		s_nxt = s_r;
		if (i_status_read) s_nxt.st_armed = 1'b1;
		clr_seq_w = s_r.st_armed && i_data_wr;
		clr_seq_r = s_r.st_armed && i_data_rd;
		if (i_data_wr || i_data_rd) s_nxt.st_armed = 1'b0;
		// Software clears first, hardware sets later win over them
		if (clr_seq_w) begin
			s_nxt.txe = 1'b0;
			s_nxt.txdone = 1'b0;
		end
		if (i_data_wr) begin
			s_nxt.thold = {i_tx_ninth_bit, i_data_wdata};
			s_nxt.thold_v = 1'b1;
		end
		if (clr_seq_r) begin
			s_nxt.rxfull = 1'b0;
			s_nxt.idle = 1'b0;
			s_nxt.ovr = 1'b0;
			s_nxt.nf = 1'b0;
			s_nxt.fe = 1'b0;
			s_nxt.pe = 1'b0;
		end
		if (i_rx_mute_set) s_nxt.mute = 1'b1;
		s_nxt.tx_on_d = i_tx_on;
		// Off then on during a word: idle next, pending data lost
		if (i_tx_on && !s_r.tx_on_d && s_r.txs != TX_OFF) begin
			s_nxt.idle_pend = 1'b1;
			s_nxt.thold_v = 1'b0;
		end
		case (s_r.txs)
			TX_OFF: begin
				s_nxt.txd = 1'b1;
				s_nxt.thold_v = 1'b0;
				if (i_tx_on) begin
					s_nxt.txs = TX_SHIFT;
					s_nxt.tsh = '1;
					s_nxt.tbits = tlen + 4'h1;
					s_nxt.tsub = '0;
					s_nxt.brk_frame = 1'b0;
				end
			end
			TX_IDLE: begin
				// Stay low between back-to-back break frames
				s_nxt.txd = !(i_break_send && i_tx_on);
				if (!i_tx_on) begin
					s_nxt.txs = TX_OFF;
				end else if (i_break_send) begin
					s_nxt.txs = TX_SHIFT;
					s_nxt.tsh = '0;
					s_nxt.tbits = tlen + 4'h1;
					s_nxt.tsub = '0;
					s_nxt.brk_frame = 1'b1;
				end else if (s_r.idle_pend) begin
					s_nxt.idle_pend = 1'b0;
					s_nxt.txs = TX_SHIFT;
					s_nxt.tsh = '1;
					s_nxt.tbits = tlen + 4'h1;
					s_nxt.tsub = '0;
					s_nxt.brk_frame = 1'b0;
				end else if (s_nxt.thold_v) begin
					// Direct load when idle; buffer empty again at once
					s_nxt.txs = TX_SHIFT;
					s_nxt.tsh = mk_frame(s_nxt.thold, i_word9, i_parity_on,
						i_odd_parity_select);
					s_nxt.tbits = tlen + 4'h1;
					s_nxt.tsub = '0;
					s_nxt.thold_v = 1'b0;
					s_nxt.txe = 1'b1;
					s_nxt.brk_frame = 1'b0;
				end
			end
			TX_SHIFT: begin
				s_nxt.txd = s_r.tsh[0];
				if (tx_tick) begin
					s_nxt.tsub = s_r.tsub + 4'h1;
					if (s_r.tsub == asu_pkg::SAMPLE_LAST) begin
						s_nxt.tsh = {1'b1, s_r.tsh[10:1]};
						s_nxt.tbits = s_r.tbits - 4'h1;
						if (s_r.tbits == 4'h2) begin // Frame is tlen bits long
							s_nxt.txdone = 1'b1;
							s_nxt.txs = (s_r.brk_frame && !i_break_send) ? TX_MARK : TX_IDLE;
							if (s_r.brk_frame && i_break_send) s_nxt.txs = TX_IDLE;
						end
					end
				end
				if (s_r.brk_frame) s_nxt.txd = 1'b0;
			end
			TX_MARK: begin
				// One mark bit so the next start bit is seen
				s_nxt.txd = 1'b1;
				if (tx_tick) begin
					s_nxt.tsub = s_r.tsub + 4'h1;
					if (s_r.tsub == asu_pkg::SAMPLE_LAST) s_nxt.txs = TX_IDLE;
				end
			end
			default: s_nxt.txs = TX_OFF;
		endcase
		// Receiver: 16x sampling, vote over three centre samples
		case (s_r.rxs)
			RX_OFF: begin
				if (i_rx_on) s_nxt.rxs = RX_HUNT;
			end
			RX_HUNT: begin
				if (rx_tick && !i_rx_line) begin
					s_nxt.rxs = RX_FRAME;
					s_nxt.rsub = 4'h1;
					s_nxt.rbit = '0;
					s_nxt.votes = '0;
					s_nxt.rnoise = 1'b0;
					s_nxt.rpar_on = i_parity_on;
					s_nxt.rodd = i_odd_parity_select;
				end else if (rx_tick) begin
					s_nxt.rsub = s_r.rsub + 4'h1;
					// Full mark frame time on the line counts as idle
					if (s_r.rsub == asu_pkg::SAMPLE_LAST) begin
						s_nxt.rbit = s_r.rbit + 4'h1;
						if (s_r.rbit == tlen && s_r.rxfull) begin
							s_nxt.rbit = tlen;
						end else if (s_r.rbit == tlen) begin
							s_nxt.rbit = 4'hf;
							if (s_r.mute && !i_wake_address) begin
								s_nxt.mute = 1'b0;
							end else if (!s_r.mute) begin
								s_nxt.idle = 1'b1;
								s_nxt.rxfull = 1'b1;
							end
						end else if (s_r.rbit == 4'hf) begin
							s_nxt.rbit = 4'hf;
						end
					end
				end
			end
			RX_FRAME: begin
				if (rx_tick) begin
					s_nxt.rsub = s_r.rsub + 4'h1;
					if (s_r.rsub == asu_pkg::SAMPLE_A || s_r.rsub == asu_pkg::SAMPLE_B ||
						s_r.rsub == asu_pkg::SAMPLE_C) begin
						s_nxt.votes = {s_r.votes[1:0], i_rx_line};
					end
					if (s_r.rsub == asu_pkg::SAMPLE_LAST) begin
						samp = (s_r.votes[0] & s_r.votes[1]) | (s_r.votes[0] & s_r.votes[2]) |
							(s_r.votes[1] & s_r.votes[2]);
						if (s_r.votes != 3'h0 && s_r.votes != 3'h7) s_nxt.rnoise = 1'b1;
						s_nxt.rsh = {samp, s_r.rsh[9:1]};
						s_nxt.rbit = s_r.rbit + 4'h1;
						if (s_r.rbit == tlen - 4'h1) begin // Stop slot is the last one
							s_nxt.rxs = RX_HUNT;
							s_nxt.rsub = '0;
							s_nxt.rbit = '0;
							rd = i_word9 ? s_nxt.rsh[8:0] : {1'b0, s_nxt.rsh[8:1]};
							perr = s_r.rpar_on &&
								(par_bit(rd, i_word9, s_r.rodd) != (i_word9 ? rd[8] : rd[7]));
							if (s_r.mute && i_wake_address && (i_word9 ? rd[8] : rd[7])) begin
								s_nxt.mute = 1'b0;
							end
							if (!s_nxt.mute) begin
								if (s_r.rxfull) begin
									s_nxt.ovr = 1'b1;
								end else begin
									s_nxt.rxfull = 1'b1;
									s_nxt.rhold = rd[7:0];
									s_nxt.r9 = i_word9 ? rd[8] : s_r.r9;
									s_nxt.nf = s_nxt.rnoise;
									s_nxt.fe = !samp;
									s_nxt.pe = perr;
								end
							end
						end
					end
				end
			end
			default: s_nxt.rxs = RX_OFF;
		endcase
		if (!i_rx_on) begin
			s_nxt.rxs = RX_OFF;
			s_nxt.rsub = '0;
			s_nxt.rbit = '0;
			s_nxt.rxfull = 1'b0;
			s_nxt.idle = 1'b0;
			s_nxt.ovr = 1'b0;
			s_nxt.nf = 1'b0;
			s_nxt.fe = 1'b0;
		end
		if (!i_tx_on && s_r.txs == TX_IDLE) s_nxt.txs = TX_OFF;
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			s_r <= '0;
			s_r.txs <= TX_OFF;
			s_r.rxs <= RX_OFF;
			s_r.txe <= asu_pkg::TXE_RESET;
			s_r.txdone <= asu_pkg::TXDONE_RESET;
			s_r.tsh <= '1;
			s_r.txd <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_tx_line = s_r.txd;
	assign o_tx_line_oe = (s_r.txs != TX_OFF);
	assign o_rx_holding_reg = s_r.rhold;
	assign o_rx_ninth_bit = s_r.r9;
	assign o_tx_buffer_empty = s_r.txe;
	assign o_tx_done_flag = s_r.txdone;
	assign o_rx_buffer_full = s_r.rxfull;
	assign o_idle_flag = s_r.idle;
	assign o_overrun_flag = s_r.ovr;
	assign o_noise_flag = s_r.nf;
	assign o_framing_fault_flag = s_r.fe;
	assign o_parity_fault_flag = s_r.pe;
	assign o_rx_mute = s_r.mute;
	// One shared line; mute blocks full, overrun and idle events, not parity fault
	assign o_irq = !i_global_mask && (
		(s_r.txe && i_txe_irq_en) || (s_r.txdone && i_txdone_irq_en) ||
		(!s_r.mute && ((s_r.rxfull || s_r.ovr) && i_rx_irq_en)) ||
		(!s_r.mute && s_r.idle && i_idle_irq_en) ||
		(s_r.pe && i_parity_irq_en));
endmodule

// *** verif/asu_checker.sv ***
/*
 * Port-level assertions for the serial transceiver core.
 * Assumes one clock domain; bound into every asu_core instance.
 */
`timescale 1ns/100ps
module asu_checker (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_tx_on,
	input wire logic i_rx_on,
	input wire logic i_global_mask,
	input wire logic i_rx_irq_en,
	input wire logic i_parity_irq_en,
	input wire logic [7:0] o_rx_holding_reg,
	input wire logic o_tx_line,
	input wire logic o_tx_line_oe,
	input wire logic o_rx_buffer_full,
	input wire logic o_overrun_flag,
	input wire logic o_noise_flag,
	input wire logic o_framing_fault_flag,
	input wire logic o_parity_fault_flag,
	input wire logic o_rx_mute,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// Interrupt gating by mask and enables
	property p_mask; o_irq |-> !i_global_mask; endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
	property p_rx_irq;
		!i_global_mask && i_rx_irq_en && !o_rx_mute && (o_rx_buffer_full || o_overrun_flag)
			|-> o_irq;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
	property p_par_irq; !i_global_mask && i_parity_irq_en && o_parity_fault_flag |-> o_irq;
	endproperty
	a_par_irq: assert property (p_par_irq) else $error("parity irq missing");
	// Transmitter start: pin claimed, then a run of mark
	property p_oe; $rose(i_tx_on) |=> o_tx_line_oe; endproperty
	a_oe: assert property (p_oe) else $error("tx pin not claimed");
	property p_idle_first; $rose(o_tx_line_oe) |-> o_tx_line [*8]; endproperty
	a_idle_first: assert property (p_idle_first) else $error("no idle lead");
	// Framing flag only rises with a completed word; rx off clears flags; overrun keeps data
	property p_fe; $rose(o_framing_fault_flag) |-> $rose(o_rx_buffer_full) || $rose(o_overrun_flag);
	endproperty
	a_fe: assert property (p_fe) else $error("framing flag alone");
	property p_rxoff;
		!i_rx_on |=> !(o_rx_buffer_full || o_overrun_flag || o_noise_flag || o_framing_fault_flag);
	endproperty
	a_rxoff: assert property (p_rxoff) else $error("rx flags kept");
	property p_ovr_keep; $rose(o_overrun_flag) |-> $stable(o_rx_holding_reg); endproperty
	a_ovr_keep: assert property (p_ovr_keep) else $error("holding overwritten");
	// Full may rise under mute only as mute drops
	property p_mute; o_rx_mute && !o_rx_buffer_full |=> !$rose(o_rx_buffer_full) || !o_rx_mute;
	endproperty
	a_mute: assert property (p_mute) else $error("flag set while muted");
	c_ovr: cover property ($rose(o_overrun_flag));
	c_fe: cover property ($rose(o_framing_fault_flag));
	c_irq: cover property ($rose(o_irq));
endmodule

bind asu_core asu_checker u_chk (.*);

// *** verif/asu_remote_node.sv ***
/*
 * Remote serial node: sends whole frames on the receive line and
 * decodes frames from the transmit line. Assumes BIT_CLKS clocks a bit.
 */
`timescale 1ns/100ps
module asu_remote_node #(
	parameter int BIT_CLKS = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_tx_line,
	output logic o_rx_line
);
	logic [10:0] got;
	int got_n;
	// Line rests at mark
	initial begin
		o_rx_line = 1'b1;
		got = '0;
		got_n = 0;
	end
	// Start bit at index 0, LSB first; mark again after the frame
	task automatic send(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			o_rx_line = bits[i];
			repeat (BIT_CLKS) @(negedge i_clk_sys);
		end
		o_rx_line = 1'b1;
	endtask
	// Mid-bit sampling of eleven slots from the falling start edge
	initial forever begin
		@(negedge i_tx_line);
		for (int i = 0; i < 11; i++) begin
			repeat (i == 0 ? BIT_CLKS / 2 : BIT_CLKS) @(posedge i_clk_sys);
			got[i] = i_tx_line;
		end
		got_n++;
	end
endmodule

// *** verif/asu_core_bench.sv ***
/*
 * Self-checking bench for asu_core: random frames both ways in all
 * parity modes, break, overrun, framing and mute wake.
 * Assumes the checker is bound and baud is at the fastest setting.
 */
`timescale 1ns/100ps
module asu_core_bench;
	logic i_clk_sys, i_nrst, i_tx_on, i_rx_on, i_break_send, i_word9, i_wake_address;
	logic i_parity_on, i_odd_parity_select, i_parity_irq_en, i_rx_irq_en, i_txe_irq_en;
	logic i_txdone_irq_en, i_idle_irq_en, i_global_mask, i_rx_mute_set, i_status_read;
	logic i_data_wr, i_tx_ninth_bit, i_data_rd, i_rx_line, o_tx_line, o_tx_line_oe;
	logic [1:0] i_common_prescale_field;
	logic [2:0] i_tx_rate_field, i_rx_rate_field;
	logic [7:0] i_tx_fine_divisor, i_rx_fine_divisor, i_data_wdata, o_rx_holding_reg;
	logic o_rx_ninth_bit, o_tx_buffer_empty, o_tx_done_flag, o_rx_buffer_full, o_idle_flag;
	logic o_overrun_flag, o_noise_flag, o_framing_fault_flag, o_parity_fault_flag;
	logic o_rx_mute, o_irq;
	int error_cnt, tests_run;
	asu_core u_dut (.*);
	asu_remote_node u_node (.i_clk_sys(i_clk_sys), .i_tx_line(o_tx_line), .o_rx_line(i_rx_line));

	// 40 MHz system clock
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Expected frame, start at index 0; parity takes the data MSB
	function automatic logic [10:0] mk(input logic [8:0] d, input logic w9, pon, odd);
		logic [8:0] x;
		x = d;
		if (w9) begin
			if (pon) x[8] = ^x[7:0] ^ odd;
			return {1'b1, x, 1'b0};
		end
		if (pon) x[7] = ^x[6:0] ^ odd;
		return {2'b11, x[7:0], 1'b0};
	endfunction

	// Status access, then one data access; strobes one cycle wide
	task automatic seq(input bit wr, input logic [8:0] d);
		i_status_read = 1'b1;
		@(negedge i_clk_sys);
		i_status_read = 1'b0;
		{i_tx_ninth_bit, i_data_wdata} = d;
		if (wr) i_data_wr = 1'b1;
		else i_data_rd = 1'b1;
		@(negedge i_clk_sys);
		{i_data_wr, i_data_rd} = 2'b00;
		@(negedge i_clk_sys);
	endtask

	// Bounded wait on full or overrun
	task automatic wait_rx(input bit ovr);
		for (int i = 0; i < 400 && (ovr ? o_overrun_flag : o_rx_buffer_full) !== 1'b1; i++)
			@(negedge i_clk_sys);
	endtask

	// Random interrupt enables and mask for each transmit and receive loop frame
	task automatic rnd_irq;
		{i_parity_irq_en, i_rx_irq_en, i_txe_irq_en, i_txdone_irq_en, i_idle_irq_en,
			i_global_mask} = 6'($urandom);
	endtask

	// Main sequence: reset, transmit, break, receive, overrun, framing, mute
	initial begin
		logic [8:0] d, d1;
		logic [10:0] fr;
		logic w9, pon, odd, bad, acc;
		int gn;
		error_cnt = 0;
		tests_run = 0;
		{i_tx_on, i_rx_on, i_break_send, i_word9, i_wake_address, i_parity_on} = '0;
		{i_odd_parity_select, i_rx_mute_set, i_status_read, i_data_wr, i_data_rd} = '0;
		{i_data_wdata, i_tx_ninth_bit} = '0;
		void'($urandom(32'h5c0c));
		rnd_irq();
		i_common_prescale_field = 2'h0;
		{i_tx_rate_field, i_rx_rate_field, i_tx_fine_divisor, i_rx_fine_divisor} = '0;
		i_nrst = 1'b0;
		repeat (6) @(negedge i_clk_sys);
		i_nrst = 1'b1;
		chk({o_tx_buffer_empty, o_tx_done_flag, o_rx_buffer_full, o_tx_line, o_tx_line_oe},
			{asu_pkg::TXE_RESET, asu_pkg::TXDONE_RESET, 3'b010});
		$display("reset test done");
		i_tx_on = 1'b1;
		for (int k = 0; k < 8; k++) begin
			{w9, pon, odd} = 3'(k);
			{i_word9, i_parity_on, i_odd_parity_select} = {w9, pon, odd};
			rnd_irq();
			d = 9'($urandom);
			gn = u_node.got_n;
			seq(1'b1, d);
			if (k == 0) begin
				chk({o_tx_buffer_empty, o_tx_done_flag}, 11'h0);
				acc = 1'b1;
				repeat (140) begin
					acc &= o_tx_line;
					@(negedge i_clk_sys);
				end
				chk(acc, 1'b1);
			end
			for (int i = 0; i < 600 && u_node.got_n == gn; i++) @(negedge i_clk_sys);
			repeat (16) @(negedge i_clk_sys);
			chk(u_node.got, mk(d, w9, pon, odd));
			chk(o_tx_done_flag, 1'b1);
		end
		$display("transmit test done");
		i_break_send = 1'b1;
		repeat (40) @(negedge i_clk_sys);
		acc = 1'b1;
		repeat (300) begin
			acc &= !o_tx_line;
			@(negedge i_clk_sys);
		end
		chk(acc, 1'b1);
		i_break_send = 1'b0;
		for (int i = 0; i < 400 && o_tx_line !== 1'b1; i++) @(negedge i_clk_sys);
		chk(o_tx_line, 1'b1);
		$display("break test done");
		i_rx_on = 1'b1;
		repeat (200) @(negedge i_clk_sys);
		seq(1'b0, 9'h0);
		for (int k = 0; k < 8; k++) begin
			{w9, pon, odd} = 3'(k);
			{i_word9, i_parity_on, i_odd_parity_select} = {w9, pon, odd};
			rnd_irq();
			bad = pon & 1'($urandom);
			fr = mk(9'($urandom), w9, pon, odd);
			fr[w9 ? 9 : 8] ^= bad;
			u_node.send(fr, w9 ? 11 : 10);
			wait_rx(1'b0);
			chk(o_rx_holding_reg, fr[8:1]);
			if (w9) chk(o_rx_ninth_bit, fr[9]);
			chk({o_parity_fault_flag, o_noise_flag, o_framing_fault_flag}, {bad, 2'b00});
			seq(1'b0, 9'h0);
			chk({o_rx_buffer_full, o_parity_fault_flag}, 11'h0);
		end
		$display("receive test done");
		{i_word9, i_parity_on} = 2'b00;
		d1 = 9'($urandom);
		u_node.send(mk(d1, 1'b0, 1'b0, 1'b0), 10);
		wait_rx(1'b0);
		u_node.send(mk(~d1, 1'b0, 1'b0, 1'b0), 10);
		wait_rx(1'b1);
		chk({o_overrun_flag, o_rx_holding_reg}, {1'b1, d1[7:0]});
		seq(1'b0, 9'h0);
		chk(o_overrun_flag, 1'b0);
		fr = mk(9'($urandom), 1'b0, 1'b0, 1'b0);
		fr[9] = 1'b0;
		u_node.send(fr, 10);
		wait_rx(1'b0);
		chk(o_framing_fault_flag, 1'b1);
		i_rx_on = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		chk({o_rx_buffer_full, o_framing_fault_flag, o_idle_flag}, 11'h0);
		$display("error flag test done");
		i_rx_on = 1'b1;
		repeat (200) @(negedge i_clk_sys);
		seq(1'b0, 9'h0);
		i_wake_address = 1'b1;
		i_rx_mute_set = 1'b1;
		@(negedge i_clk_sys);
		i_rx_mute_set = 1'b0;
		u_node.send(mk(9'h05a, 1'b0, 1'b0, 1'b0), 10);
		wait_rx(1'b0);
		chk({o_rx_buffer_full, o_rx_mute}, 2'b01);
		u_node.send(mk(9'h0c3, 1'b0, 1'b0, 1'b0), 10);
		wait_rx(1'b0);
		chk({o_rx_buffer_full, o_rx_mute, o_rx_holding_reg}, {2'b10, 8'hc3});
		$display("mute test done");
		tally_and_finish();
	end

	// Hang guard, well beyond the expected run length
	initial begin
		repeat (40000) @(posedge i_clk_sys);
		error_cnt++;
		tally_and_finish();
	end
endmodule
